//--- hw/psm_blank_filter.sv
`timescale 1ns/1ps
`default_nettype none
`include "psm_consts.svh"
// accepts a falling edge only after the input stood high for the blanking time
module psm_blank_filter #(
  parameter int BLANK_CYC = `PSM_BLANK_CYC
) (
  input  wire logic mclk_in,
  input  wire logic rst_in,
  input  wire logic sense_in,
  output logic      fall_out
);
  // the counter is eight bits wide
  if (BLANK_CYC < 1 || BLANK_CYC > 256) begin
    $error("blanking must be 1 to 256 cycles");
  end

  typedef struct packed {
    logic [7:0] cnt;
    logic       armed;
    logic       prev;
    logic       fall;
  } psm_blank_s;

  psm_blank_s st_ff;
  psm_blank_s nxt_st;

  always_comb begin
    nxt_st      = st_ff;
    nxt_st.prev = sense_in;
    nxt_st.fall = 1'b0;
    if (sense_in) begin
      if (st_ff.cnt >= 8'(BLANK_CYC - 1)) begin
        nxt_st.armed = 1'b1;
      end else begin
        nxt_st.cnt = st_ff.cnt + 8'h01;
      end
    end else begin
      // short high pulses never arm, so their edges are ignored
      nxt_st.fall  = st_ff.prev && st_ff.armed;
      nxt_st.armed = 1'b0;
      nxt_st.cnt   = 8'h00;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign fall_out = st_ff.fall;
endmodule
`default_nettype wire

//--- hw/psm_consts.svh
`ifndef PSM_CONSTS_SVH
`define PSM_CONSTS_SVH
`define PSM_CLK_MHZ          125
`define PSM_BLANK_NS         200
`define PSM_BLANK_CYC        ((`PSM_BLANK_NS * `PSM_CLK_MHZ + 999) / 1000)
`define PSM_FMAX_KHZ         70
`define PSM_MIN_PERIOD_CYC   ((`PSM_CLK_MHZ * 1000 + `PSM_FMAX_KHZ - 1) / `PSM_FMAX_KHZ)
`define PSM_STARTUP_PCT      90
`define PSM_NORMAL_PCT       100
`define PSM_BURST_PCT        5
`define PSM_PCT_FULL         100
`endif

//--- hw/psm_mode_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "psm_consts.svh"
// Notes on behaviour
// - startup at power-up or link below 90%
// - leave startup only at full nominal link
// - power-up always enters startup mode
// - startup on-time gives constant peak current
// - startup off-time from boundary condition
// - startup switches in boundary conduction
// - burst mode below 5% output power
// - burst suppresses whole half-line periods
// - cycle starts on demag sense fall
// - light load modulates on-time
// - frequency adapts to line sample
// - switching never above 70 kHz
// - discontinuous normally, near-boundary at peaks
// - demag edge needs 200 ns high first
module psm_mode_ctrl #(
  parameter int          W         = 12,
  parameter logic [11:0] LINK_NOM  = 12'hC00,
  parameter logic [11:0] POWER_NOM = 12'hC00,
  parameter logic [11:0] LINE_LOW  = 12'h400,
  parameter logic [15:0] TON_MAX   = 16'h0800,
  parameter logic [15:0] TOFF_BASE = 16'h0200
) (
  input  wire logic              mclk_in,
  input  wire logic              rst_in,
  input  wire psm_pkg::psm_meas_s meas_in,
  input  wire logic              sample_in,
  input  wire logic              half_line_in,
  input  wire logic              demag_sense_in,
  output logic                   gate_drive_out,
  output psm_pkg::psm_mode_e     mode_out,
  output logic                   boundary_conduction_out,
  output logic                   near_boundary_conduction_out,
  output logic                   discontinuous_conduction_out
);
  if (W != 12) begin
    $error("measurement width must be 12");
  end
  if (LINK_NOM == 12'h000 || POWER_NOM == 12'h000) begin
    $error("nominal link and power must be nonzero");
  end
  if (TON_MAX == 16'h0000) begin
    $error("maximum on-time must be nonzero");
  end
  if (LINE_LOW == 12'h000) begin
    $error("low-line threshold must be nonzero");
  end
  // the cycle counter saturates, so on-time plus dead time must stay below it
  if (int'(TON_MAX) + int'(TOFF_BASE) >= 65535) begin
    $error("on-time plus dead time too long");
  end

  localparam logic [23:0] TH_START = 24'(LINK_NOM * `PSM_STARTUP_PCT / `PSM_PCT_FULL);
  localparam logic [23:0] TH_NORM  = 24'(LINK_NOM * `PSM_NORMAL_PCT / `PSM_PCT_FULL);
  localparam logic [23:0] TH_BURST = 24'(POWER_NOM * `PSM_BURST_PCT / `PSM_PCT_FULL);
  localparam logic [15:0] PER_MIN  = 16'(`PSM_MIN_PERIOD_CYC);

  typedef struct packed {
    psm_pkg::psm_mode_e  mode;
    psm_pkg::psm_phase_e phase;
    logic [15:0]         cnt;
    logic [15:0]         ton;
    logic [15:0]         toff;
    logic                skip;
    logic                gate;
    logic                bcm;
    logic                qbcm;
    logic                discontinuous_conduction;
  } psm_state_s;

  // saturated count lets the first cycle after reset start at once
  localparam psm_state_s ST_RESET = '{
    mode:  psm_pkg::PSM_STARTUP,
    phase: psm_pkg::PSM_IDLE,
    cnt:   16'hFFFF,
    ton:   16'h0000,
    toff:  16'h0000,
    skip:  1'b0,
    gate:  1'b0,
    bcm:   1'b0,
    qbcm:  1'b0,
    discontinuous_conduction:   1'b0
  };

  psm_state_s st_ff;
  psm_state_s nxt_st;
  logic       demag_fall;

  psm_blank_filter #(
    .BLANK_CYC(`PSM_BLANK_CYC)
  ) u_blank (
    .mclk_in (mclk_in),
    .rst_in  (rst_in),
    .sense_in(demag_sense_in),
    .fall_out(demag_fall)
  );

  // on-time scaled by a 12-bit fraction of the max
  function automatic logic [15:0] scale(input logic [15:0] full, input logic [11:0] frac);
    logic [27:0] p;
    p = full * frac;
    return p[27:12];
  endfunction

  function automatic logic at_least(input logic [11:0] value, input logic [23:0] th);
    return {12'h000, value} >= th;
  endfunction

  // low line near its peak at full load runs near-boundary
  function automatic logic near_peak(input psm_pkg::psm_meas_s m);
    return (m.line < LINE_LOW) && (m.power >= POWER_NOM);
  endfunction

  // a zero product would still give a one-cycle pulse; make that explicit
  function automatic logic [15:0] on_time(input logic [11:0] power);
    logic [15:0] t;
    t = scale(TON_MAX, power);
    return (t == 16'h0000) ? 16'h0001 : t;
  endfunction

  always_comb begin
    nxt_st = st_ff;
    // mode selection with hysteresis, once per sample
    if (sample_in) begin
      case (st_ff.mode)
        psm_pkg::PSM_STARTUP: begin
          if (at_least(meas_in.link, TH_NORM)) begin
            nxt_st.mode = psm_pkg::PSM_NORMAL;
          end
        end
        psm_pkg::PSM_NORMAL, psm_pkg::PSM_BURST: begin
          if (!at_least(meas_in.link, TH_START)) begin
            nxt_st.mode = psm_pkg::PSM_STARTUP;
          end else if (!at_least(meas_in.power, TH_BURST)) begin
            nxt_st.mode = psm_pkg::PSM_BURST;
          end else begin
            nxt_st.mode = psm_pkg::PSM_NORMAL;
          end
        end
        default: nxt_st.mode = psm_pkg::PSM_STARTUP;
      endcase
    end

    // burst skips alternate whole half-lines, decided at the boundary only
    if (half_line_in) begin
      if (st_ff.mode == psm_pkg::PSM_BURST) begin
        nxt_st.skip = !st_ff.skip;
      end else begin
        nxt_st.skip = 1'b0;
      end
    end

    // count saturates; a cycle start below still clears it
    if (st_ff.cnt != 16'hFFFF) begin
      nxt_st.cnt = st_ff.cnt + 16'h0001;
    end

    // cycle sequencer: idle, gate on, dead time
    case (st_ff.phase)
      psm_pkg::PSM_IDLE: begin
        nxt_st.gate = 1'b0;
        // period counter guards the frequency ceiling
        if (demag_fall && !st_ff.skip && st_ff.cnt >= PER_MIN) begin
          nxt_st.phase = psm_pkg::PSM_ON;
          nxt_st.gate  = 1'b1;
          nxt_st.cnt   = 16'h0000;
          if (st_ff.mode == psm_pkg::PSM_STARTUP) begin
            nxt_st.ton  = TON_MAX;
            nxt_st.toff = 16'h0000;
            nxt_st.bcm  = 1'b1;
            nxt_st.qbcm = 1'b0;
            nxt_st.discontinuous_conduction  = 1'b0;
          end else begin
            // normal and burst cycles scale with load and line
            nxt_st.ton  = on_time(meas_in.power);
            nxt_st.toff = scale(TOFF_BASE, meas_in.line);
            nxt_st.bcm  = 1'b0;
            if (near_peak(meas_in)) begin
              nxt_st.qbcm = 1'b1;
              nxt_st.discontinuous_conduction  = 1'b0;
            end else begin
              nxt_st.qbcm = 1'b0;
              nxt_st.discontinuous_conduction  = 1'b1;
            end
          end
        end
      end
      psm_pkg::PSM_ON: begin
        if (st_ff.cnt + 16'h0001 >= st_ff.ton) begin
          nxt_st.phase = psm_pkg::PSM_OFF;
          nxt_st.gate  = 1'b0;
        end
      end
      psm_pkg::PSM_OFF: begin
        // boundary cycles rearm at once; others add the dead time
        if (st_ff.cnt >= st_ff.ton + st_ff.toff) begin
          nxt_st.phase = psm_pkg::PSM_IDLE;
        end
      end
      default: nxt_st.phase = psm_pkg::PSM_IDLE;
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      // a cut cycle is dropped: gate off, sequencer idle
      st_ff <= ST_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign gate_drive_out               = st_ff.gate;
  assign mode_out                     = st_ff.mode;
  assign boundary_conduction_out      = st_ff.bcm;
  assign near_boundary_conduction_out = st_ff.qbcm;
  assign discontinuous_conduction_out = st_ff.discontinuous_conduction;
endmodule
`default_nettype wire

//--- hw/psm_pkg.sv
package psm_pkg;
  typedef enum logic [1:0] {
    PSM_STARTUP,
    PSM_NORMAL,
    PSM_BURST
  } psm_mode_e;

  typedef enum logic [1:0] {
    PSM_IDLE,
    PSM_ON,
    PSM_OFF
  } psm_phase_e;

  typedef struct packed {
    logic [11:0] link;
    logic [11:0] line;
    logic [11:0] power;
  } psm_meas_s;
endpackage

//--- testbench/pfc_switching_mode_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
module pfc_switching_mode_control_bench;
  localparam logic [15:0] TONM = 16'h0800;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic sample = 1'b0;
  logic kick = 1'b0;
  logic short_k = 1'b0;
  logic half = 1'b0;
  logic demag, gate, fb, fn, fd;
  psm_pkg::psm_meas_s meas = '{link: 12'h000, line: 12'h800, power: 12'hC00};
  psm_pkg::psm_mode_e mode;
  int miscompares = 0;
  int checks = 0;
  always #4 mclk = ~mclk;
  psm_mode_ctrl #(.TON_MAX(TONM)) u_dut (.mclk_in(mclk), .rst_in(rst), .meas_in(meas), .sample_in(sample),
    .half_line_in(half), .demag_sense_in(demag), .gate_drive_out(gate), .mode_out(mode),
    .boundary_conduction_out(fb), .near_boundary_conduction_out(fn), .discontinuous_conduction_out(fd));
  psm_power_stage u_stage (.mclk_in(mclk), .gate_in(gate), .kick_in(kick), .short_in(short_k), .demag_out(demag));
  task automatic print_verdict;
    if (miscompares == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wait_gate(input logic lv);
    for (int i = 0; i < 4000 && gate !== lv; i++) begin
      @(posedge mclk);
      #1;
    end
    chk(gate, lv);
    if (gate !== lv)
      print_verdict();
  endtask
  task automatic pulse(input logic s);
    @(posedge mclk);
    short_k <= s;
    kick <= 1'b1;
    @(posedge mclk);
    kick <= 1'b0;
  endtask
  task automatic t_glitch;
    pulse(1'b1);
    repeat (60) @(posedge mclk);
    #1;
    chk(gate, 1'b0);
  endtask
  task automatic measure_on(output logic [15:0] n);
    n = 16'h0000;
    while (gate === 1'b1 && n < 16'hF000) begin
      n++;
      @(posedge mclk);
      #1;
    end
  endtask
  task automatic take(input logic [11:0] lk, input logic [11:0] ln, input logic [11:0] pw);
    @(posedge mclk);
    meas <= '{link: lk, line: ln, power: pw};
    sample <= 1'b1;
    @(posedge mclk);
    sample <= 1'b0;
  endtask
  task automatic half_pulse;
    @(posedge mclk);
    half <= 1'b1;
    @(posedge mclk);
    half <= 1'b0;
  endtask
  task automatic t_startup;
    logic [15:0] n;
    pulse(1'b0);
    wait_gate(1'b1);
    chk(fb, 1'b1);
    chk(fd, 1'b0);
    measure_on(n);
    chk(n, TONM);
    wait_gate(1'b1);
  endtask
  task automatic t_burst;
    logic [15:0] n;
    take(12'hC00, 12'h800, 12'h010);
    // long enough for any running cycle to end and the period to lapse
    repeat (5000) @(posedge mclk);
    #1;
    chk(mode, psm_pkg::PSM_BURST);
    chk(gate, 1'b0);
    half_pulse();
    pulse(1'b0);
    repeat (80) @(posedge mclk);
    #1;
    chk(gate, 1'b0);
    half_pulse();
    pulse(1'b0);
    wait_gate(1'b1);
    chk(fb, 1'b0);
    chk(fn, 1'b0);
    chk(fd, 1'b1);
    measure_on(n);
    // full-scale on-time times 16/4096
    chk(n, 16'h0008);
  endtask
  task automatic t_peak;
    logic [15:0] n;
    take(12'hC00, 12'h100, 12'hC00);
    repeat (2000) @(posedge mclk);
    pulse(1'b0);
    wait_gate(1'b1);
    chk(mode, psm_pkg::PSM_NORMAL);
    chk(fn, 1'b1);
    chk(fd, 1'b0);
    measure_on(n);
    // full-scale on-time times 3072/4096
    chk(n, 16'h0600);
  endtask
  task automatic t_modes;
    logic [11:0] lk [7] = '{12'hB00, 12'hC00, 12'hB00, 12'hA00, 12'hC00, 12'hC00, 12'hC00};
    logic [11:0] pw [7] = '{12'hC00, 12'hC00, 12'hC00, 12'hC00, 12'hC00, 12'h010, 12'hC00};
    psm_pkg::psm_mode_e ex [7] = '{psm_pkg::PSM_STARTUP, psm_pkg::PSM_NORMAL, psm_pkg::PSM_NORMAL,
      psm_pkg::PSM_STARTUP, psm_pkg::PSM_NORMAL, psm_pkg::PSM_BURST, psm_pkg::PSM_NORMAL};
    for (int i = 0; i < 7; i++) begin
      @(posedge mclk);
      meas <= '{link: lk[i], line: 12'h800, power: pw[i]};
      sample <= 1'b1;
      @(posedge mclk);
      sample <= 1'b0;
      @(posedge mclk);
      #1;
      chk(mode, ex[i]);
    end
  endtask
  initial begin
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    #1;
    chk(gate, 1'b0);
    chk(mode, psm_pkg::PSM_STARTUP);
    t_glitch();
    t_startup();
    t_modes();
    t_burst();
    t_peak();
    print_verdict();
  end
endmodule
`default_nettype wire

//--- testbench/psm_mode_ctrl_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "psm_consts.svh"
module psm_mode_ctrl_sva #(
  parameter logic [11:0] LINK_NOM  = 12'hC00,
  parameter logic [11:0] POWER_NOM = 12'hC00,
  parameter logic [15:0] TON_MAX   = 16'h0800
) (
  input wire logic               mclk_in,
  input wire logic               rst_in,
  input wire psm_pkg::psm_meas_s meas_in,
  input wire logic               sample_in,
  input wire logic               gate_drive_out,
  input wire psm_pkg::psm_mode_e mode_out,
  input wire logic               boundary_conduction_out,
  input wire logic               near_boundary_conduction_out,
  input wire logic               discontinuous_conduction_out
);
  localparam int LOW  = int'(LINK_NOM) * `PSM_STARTUP_PCT / `PSM_PCT_FULL;
  localparam int BRST = int'(POWER_NOM) * `PSM_BURST_PCT / `PSM_PCT_FULL;
  logic [11:0] per_ff;
  logic [15:0] on_ff;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  // saturates so the first cycle after reset is never limited
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      per_ff <= 12'hFFF;
      on_ff <= 16'h0000;
    end else begin
      if ($rose(gate_drive_out))
        per_ff <= 12'h001;
      else if (per_ff != 12'hFFF)
        per_ff <= per_ff + 12'h001;
      on_ff <= gate_drive_out ? on_ff + 16'h0001 : 16'h0000;
    end
  end
  a_low_link: assert property (
    sample_in && meas_in.link < LOW |=> mode_out == psm_pkg::PSM_STARTUP)
    else $error("no startup on low link");
  a_stay_startup: assert property (
    mode_out == psm_pkg::PSM_STARTUP && sample_in && meas_in.link < LINK_NOM |=> mode_out == psm_pkg::PSM_STARTUP)
    else $error("left startup early");
  a_leave_startup: assert property (
    mode_out == psm_pkg::PSM_STARTUP && sample_in &&
    meas_in.link >= LINK_NOM && meas_in.power >= POWER_NOM |=> mode_out == psm_pkg::PSM_NORMAL)
    else $error("startup not left");
  a_burst_entry: assert property (
    mode_out == psm_pkg::PSM_NORMAL && sample_in &&
    meas_in.link >= LINK_NOM && meas_in.power < BRST |=> mode_out == psm_pkg::PSM_BURST)
    else $error("no burst");
  a_mode_held: assert property (
    !sample_in |=> $stable(mode_out))
    else $error("mode moved without sample");
  a_min_period: assert property (
    $rose(gate_drive_out) |-> per_ff >= `PSM_MIN_PERIOD_CYC)
    else $error("period too short");
  a_startup_ton: assert property (
    $fell(gate_drive_out) && $past(boundary_conduction_out) && !$past(rst_in) |-> on_ff == TON_MAX)
    else $error("startup on-time wrong");
  // the kind is chosen from the mode held before the start edge
  a_startup_kind: assert property (
    $rose(gate_drive_out) && $past(mode_out) == psm_pkg::PSM_STARTUP |-> boundary_conduction_out)
    else $error("startup not boundary");
  a_one_kind: assert property (
    $rose(gate_drive_out) |-> $onehot({boundary_conduction_out,
    near_boundary_conduction_out, discontinuous_conduction_out}))
    else $error("cycle kind not unique");
endmodule
bind psm_mode_ctrl psm_mode_ctrl_sva #(.LINK_NOM(LINK_NOM), .POWER_NOM(POWER_NOM), .TON_MAX(TON_MAX)) u_sva (
  .mclk_in(mclk_in), .rst_in(rst_in), .meas_in(meas_in), .sample_in(sample_in),
  .gate_drive_out(gate_drive_out), .mode_out(mode_out), .boundary_conduction_out(boundary_conduction_out),
  .near_boundary_conduction_out(near_boundary_conduction_out),
  .discontinuous_conduction_out(discontinuous_conduction_out));
`default_nettype wire

//--- testbench/psm_power_stage.sv
`timescale 1ns/1ps
`default_nettype none
module psm_power_stage (
  input  wire logic mclk_in,
  input  wire logic gate_in,
  input  wire logic kick_in,
  input  wire logic short_in,
  output logic      demag_out
);
  logic [5:0] ring_ff = 6'h00;
  logic       gate_ff = 1'b0;
  // aux high while the inductor empties; a short run mimics a ringing glitch
  always @(posedge mclk_in) begin
    gate_ff <= gate_in;
    if ((gate_ff && !gate_in) || kick_in)
      ring_ff <= short_in ? 6'h0A : 6'h28;
    else if (ring_ff != 6'h00)
      ring_ff <= ring_ff - 6'h01;
  end
  assign demag_out = (ring_ff != 6'h00);
endmodule
`default_nettype wire
